// ==== core/tna_pkg.sv ====
package tna_pkg;
  localparam int          NODE_COUNT     = 8;
  localparam int          NODE_IDX_W     = 8;
  localparam int          ADDR_W         = 16;
  localparam int          DATA_W         = 32;
  // Register offsets and address ranges (byte addresses)
  localparam logic [15:0] SCR_OFS        = 16'h8E18;
  localparam logic [15:0] INIT_OFS       = 16'h803C;
  localparam logic [15:0] UARCH_LO       = 16'h8E00;
  localparam logic [15:0] UARCH_HI       = 16'h8E7C;
  localparam logic [15:0] ERR_LO         = 16'h8E80;
  localparam logic [15:0] ERR_HI         = 16'h8EC0;
  localparam logic [15:0] NCTRL_LO       = 16'h9000;
  localparam logic [15:0] NCTRL_HI       = 16'h93FC;
  localparam logic [15:0] NSTAT_LO       = 16'h9400;
  localparam logic [15:0] NSTAT_HI       = 16'h97FC;
  // Secure access control fields
  localparam int          SCR_INIT_BIT   = 3;
  localparam int          SCR_ERR_BIT    = 1;
  localparam int          SCR_UARCH_BIT  = 0;
  localparam logic [31:0] SCR_MASK       = 32'h0000000B;
  // Node control fields
  localparam int          NC_EXCL_BIT    = 4;
  localparam int          NC_PRI_LSB     = 0;
  localparam int          NC_PRI_W       = 2;
  localparam logic [31:0] NC_MASK        = 32'h00000013;
  localparam logic [31:0] NC_RESET       = 32'h00000000;
  // Node status fields
  localparam int          NS_CONN_BIT    = 0;
  localparam int          NS_ATS_BIT     = 1;
  localparam logic [31:0] NSTAT_RESET    = 32'h00000000;
endpackage

// ==== core/tna_node_ctrl_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
module tna_node_ctrl_bank
  import tna_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic                        wr_en,
  input  wire logic [NODE_IDX_W-1:0]       wr_idx,
  input  wire logic [DATA_W-1:0]           wr_data,
  input  wire logic [3:0]                  wr_sel,
  input  wire logic [NODE_IDX_W-1:0]       rd_idx,
  output logic      [DATA_W-1:0]           rd_data,
  output logic      [NODE_COUNT*2-1:0]     priority_vec,
  output logic      [NODE_COUNT-1:0]       exclude_vec
);
  logic [DATA_W-1:0] ctrl      [NODE_COUNT];
  logic [DATA_W-1:0] next_ctrl [NODE_COUNT];
  logic [DATA_W-1:0] bytemask;

  always_comb begin
    bytemask = {{8{wr_sel[3]}}, {8{wr_sel[2]}}, {8{wr_sel[1]}}, {8{wr_sel[0]}}};
    for (int i = 0; i < NODE_COUNT; i++) begin
      next_ctrl[i] = ctrl[i];
      if (wr_en && wr_idx == NODE_IDX_W'(i)) begin
        // Only priority and exclude bits hold state; others read zero
        next_ctrl[i] = ((ctrl[i] & ~bytemask) | (wr_data & bytemask)) & NC_MASK;
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < NODE_COUNT; i++) begin
      ctrl[i] <= srst ? NC_RESET : next_ctrl[i];
    end
  end

  always_comb begin
    rd_data = '0;
    for (int i = 0; i < NODE_COUNT; i++) begin
      if (rd_idx == NODE_IDX_W'(i)) begin
        rd_data = ctrl[i];
      end
      priority_vec[i*2 +: 2] = ctrl[i][NC_PRI_LSB +: NC_PRI_W];
      exclude_vec[i]         = ctrl[i][NC_EXCL_BIT];
    end
  end
endmodule // tna_node_ctrl_bank
`default_nettype wire

// ==== core/tna_node_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none
module tna_node_arbiter
  import tna_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic [NODE_COUNT-1:0]       req,
  input  wire logic [NODE_COUNT*2-1:0]     priority_vec,
  output logic      [NODE_COUNT-1:0]       gnt
);
  logic [NODE_COUNT-1:0] next_gnt;
  logic [1:0]            best_pri;
  logic                  found;

  // Highest priority wins; ties go to the lowest node index
  always_comb begin
    next_gnt = '0;
    best_pri = 2'h0;
    found    = 1'b0;
    for (int i = 0; i < NODE_COUNT; i++) begin
      if (req[i] && (!found || priority_vec[i*2 +: 2] > best_pri)) begin
        next_gnt = '0;
        next_gnt[i] = 1'b1;
        best_pri = priority_vec[i*2 +: 2];
        found    = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    gnt <= srst ? '0 : next_gnt;
  end
endmodule // tna_node_arbiter
`default_nettype wire

// ==== core/tna_access_control.sv ====
// What this block does
// - Non-secure reads of secure access control return zero; non-secure writes discarded.
// - With init permit bit 3 clear, non-secure init register access is RAZ/WI.
// - With error permit bit 1 clear, non-secure error range access is RAZ/WI.
// - With uarch permit bit 0 clear, non-secure uarch and node control access RAZ/WI.
// - Reset loads the three permit bits from the secure-default input.
// - One 32-bit node control register per node, spaced four bytes apart.
// - Node control writes take effect only while both translation enables are 0.
// - Exclude bit set drops node from broadcast invalidation; ignored for root-complex nodes.
// - Node priority is bits 1:0; higher-priority requests are served first.
// - One read-only node status register per node, reset to zero.
// - Node status is meaningful only while the node is connected.
// - Status bit 1 shows buffer-unit or root-complex link protocol.
// - Status bit 0 shows whether the node link is connected.
// - Disconnected node status registers read zero; connection may change between accesses.
// - Non-secure node status reads return zero while uarch permit bit is 0.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module tna_access_control
  import tna_pkg::*;
(
  input  wire logic                        CLK_SYS,
  input  wire logic                        SRST,
  input  wire logic                        WB_CYC,
  input  wire logic                        WB_STB,
  input  wire logic                        WB_WE,
  input  wire logic [ADDR_W-1:0]           WB_ADR,
  input  wire logic [3:0]                  WB_SEL,
  input  wire logic [DATA_W-1:0]           WB_DAT_I,
  input  wire logic                        WB_NS,
  output logic      [DATA_W-1:0]           WB_DAT_O,
  output logic                             WB_ACK,
  input  wire logic                        SEC_OVERRIDE,
  input  wire logic                        XLATE_EN_S,
  input  wire logic                        XLATE_EN_NS,
  input  wire logic [NODE_COUNT-1:0]       NODE_CONNECTED,
  input  wire logic [NODE_COUNT-1:0]       NODE_ATS,
  input  wire logic [NODE_COUNT-1:0]       XLATE_REQ,
  output logic      [NODE_COUNT-1:0]       XLATE_GNT,
  output logic      [NODE_COUNT*2-1:0]     NODE_PRIORITY,
  output logic      [NODE_COUNT-1:0]       NODE_INVAL_EXCLUDE,
  output logic                             NONSECURE_INIT_PERMIT,
  output logic                             NONSECURE_ERROR_REGS_PERMIT,
  output logic                             NONSECURE_UARCH_PERMIT,
  output logic                             NS_ACCESS_DENIED
);

  function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // Whether a non-secure access to this address is blocked by the permit bits
  function automatic logic ns_blocked(input logic [ADDR_W-1:0] a,
                                      input logic [DATA_W-1:0] scr);
    logic blk;
    blk = 1'b0;
    if (a == SCR_OFS) begin
      blk = 1'b1;
    end else if (a == INIT_OFS) begin
      blk = !scr[SCR_INIT_BIT];
    end else if (in_range(a, ERR_LO, ERR_HI)) begin
      blk = !scr[SCR_ERR_BIT];
    end else if (in_range(a, UARCH_LO, UARCH_HI) || in_range(a, NCTRL_LO, NCTRL_HI)) begin
      blk = !scr[SCR_UARCH_BIT];
    end else if (in_range(a, NSTAT_LO, NSTAT_HI)) begin
      blk = !scr[SCR_UARCH_BIT];
    end
    return blk;
  endfunction

  // Secure-default input synchroniser
  logic sec_meta;
  logic sec_sync;

  always_ff @(posedge CLK_SYS) begin
    sec_meta <= SEC_OVERRIDE;
    sec_sync <= sec_meta;
  end

  // Bus and register state
  logic [DATA_W-1:0]     scr;
  logic [DATA_W-1:0]     next_scr;
  logic                  ack;
  logic                  next_ack;
  logic [DATA_W-1:0]     rdata;
  logic [DATA_W-1:0]     next_rdata;
  logic                  denied;
  logic                  next_denied;

  logic                  req_new;
  logic                  blocked;
  logic                  wr_ok;
  logic [DATA_W-1:0]     bytemask;
  logic [NODE_IDX_W-1:0] node_idx;
  logic                  nctrl_hit;
  logic                  nstat_hit;
  logic                  nctrl_wr;
  logic [DATA_W-1:0]     nctrl_rdata;
  logic [DATA_W-1:0]     nstat_rdata;
  logic [NODE_COUNT-1:0] excl_raw;

  always_comb begin
    req_new   = WB_CYC && WB_STB && !ack;
    blocked   = WB_NS && ns_blocked(WB_ADR, scr);
    wr_ok     = req_new && WB_WE && !blocked;
    bytemask  = {{8{WB_SEL[3]}}, {8{WB_SEL[2]}}, {8{WB_SEL[1]}}, {8{WB_SEL[0]}}};
    node_idx  = WB_ADR[NODE_IDX_W+1:2];
    nctrl_hit = in_range(WB_ADR, NCTRL_LO, NCTRL_HI);
    nstat_hit = in_range(WB_ADR, NSTAT_LO, NSTAT_HI);
    nctrl_wr  = wr_ok && nctrl_hit && !XLATE_EN_S && !XLATE_EN_NS;
  end

  // Node status view: zero for absent or disconnected nodes
  always_comb begin
    nstat_rdata = NSTAT_RESET;
    for (int i = 0; i < NODE_COUNT; i++) begin
      if (node_idx == NODE_IDX_W'(i) && NODE_CONNECTED[i]) begin
        nstat_rdata[NS_CONN_BIT] = 1'b1;
        nstat_rdata[NS_ATS_BIT]  = NODE_ATS[i];
      end
    end
  end

  always_comb begin
    next_scr    = scr;
    next_ack    = WB_CYC && WB_STB && !ack;
    next_rdata  = rdata;
    next_denied = 1'b0;
    if (wr_ok && WB_ADR == SCR_OFS) begin
      next_scr = ((scr & ~bytemask) | (WB_DAT_I & bytemask)) & SCR_MASK;
    end
    if (req_new) begin
      next_denied = blocked;
      next_rdata  = '0;
      if (!WB_WE && !blocked) begin
        if (WB_ADR == SCR_OFS) begin
          next_rdata = scr;
        end else if (nctrl_hit) begin
          next_rdata = nctrl_rdata;
        end else if (nstat_hit) begin
          next_rdata = nstat_rdata;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      scr    <= {28'h0000000, sec_sync, 1'b0, sec_sync, sec_sync};
      ack    <= 1'b0;
      rdata  <= '0;
      denied <= 1'b0;
    end else begin
      scr    <= next_scr;
      ack    <= next_ack;
      rdata  <= next_rdata;
      denied <= next_denied;
    end
  end

  tna_node_ctrl_bank u_bank (
    .clk          (CLK_SYS),
    .srst         (SRST),
    .wr_en        (nctrl_wr),
    .wr_idx       (node_idx),
    .wr_data      (WB_DAT_I),
    .wr_sel       (WB_SEL),
    .rd_idx       (node_idx),
    .rd_data      (nctrl_rdata),
    .priority_vec (NODE_PRIORITY),
    .exclude_vec  (excl_raw)
  );

  tna_node_arbiter u_arb (
    .clk          (CLK_SYS),
    .srst         (SRST),
    .req          (XLATE_REQ),
    .priority_vec (NODE_PRIORITY),
    .gnt          (XLATE_GNT)
  );

  always_comb begin
    NODE_INVAL_EXCLUDE          = excl_raw & ~(NODE_ATS & NODE_CONNECTED);
    NONSECURE_INIT_PERMIT       = scr[SCR_INIT_BIT];
    NONSECURE_ERROR_REGS_PERMIT = scr[SCR_ERR_BIT];
    NONSECURE_UARCH_PERMIT      = scr[SCR_UARCH_BIT];
    WB_ACK                      = ack;
    WB_DAT_O                    = rdata;
    NS_ACCESS_DENIED            = denied;
  end
endmodule // tna_access_control
`default_nettype wire

// ==== dv/tna_access_control_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module tna_ac_chk
  import tna_pkg::*;
(
  input wire logic                    CLK_SYS,
  input wire logic                    SRST,
  input wire logic                    WB_CYC,
  input wire logic                    WB_STB,
  input wire logic                    WB_WE,
  input wire logic [ADDR_W-1:0]       WB_ADR,
  input wire logic                    WB_NS,
  input wire logic [DATA_W-1:0]       WB_DAT_O,
  input wire logic                    WB_ACK,
  input wire logic                    SEC_OVERRIDE,
  input wire logic                    XLATE_EN_S,
  input wire logic                    XLATE_EN_NS,
  input wire logic [NODE_COUNT-1:0]   XLATE_REQ,
  input wire logic [NODE_COUNT-1:0]   XLATE_GNT,
  input wire logic [NODE_COUNT*2-1:0] NODE_PRIORITY,
  input wire logic                    NONSECURE_INIT_PERMIT,
  input wire logic                    NONSECURE_ERROR_REGS_PERMIT,
  input wire logic                    NONSECURE_UARCH_PERMIT,
  input wire logic                    NS_ACCESS_DENIED
);
  logic       tk;
  logic [2:0] pm;
  assign tk = WB_CYC && WB_STB && !WB_ACK;
  assign pm = {NONSECURE_INIT_PERMIT, NONSECURE_ERROR_REGS_PERMIT, NONSECURE_UARCH_PERMIT};
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  ack_timing_a: assert property (tk |=> WB_ACK ##1 !WB_ACK) else $error("ack timing wrong");
  scr_raz_a: assert property (tk && WB_NS && WB_ADR == SCR_OFS |=> NS_ACCESS_DENIED && WB_DAT_O == 0)
    else $error("nonsecure control read leaked");
  scr_wi_a: assert property (tk && WB_NS && WB_WE && WB_ADR == SCR_OFS |=> pm == $past(pm))
    else $error("nonsecure control write landed");
  init_gate_a: assert property (tk && WB_NS && WB_ADR == INIT_OFS |=> NS_ACCESS_DENIED == !$past(pm[2]))
    else $error("init gating wrong");
  err_gate_a: assert property (tk && WB_NS && WB_ADR inside {[ERR_LO:ERR_HI]} |=> NS_ACCESS_DENIED == !$past(pm[1]))
    else $error("error range gating wrong");
  node_gate_a: assert property (tk && WB_NS && WB_ADR inside {[NCTRL_LO:NSTAT_HI]} |=> NS_ACCESS_DENIED == !$past(pm[0]))
    else $error("node range gating wrong");
  denied_zero_a: assert property (NS_ACCESS_DENIED |-> WB_ACK && WB_DAT_O == 0)
    else $error("denied access returned data");
  ctrl_lock_a: assert property (tk && WB_WE && WB_ADR inside {[NCTRL_LO:NCTRL_HI]} && (XLATE_EN_S || XLATE_EN_NS)
    |=> $stable(NODE_PRIORITY)) else $error("locked node write landed");
  grant_req_a: assert property (XLATE_GNT != 0 |-> $onehot(XLATE_GNT) && (XLATE_GNT & ~$past(XLATE_REQ)) == 0)
    else $error("grant without request");
  reset_load_a: assert property (disable iff (1'b0) $fell(SRST) |-> pm == {3{SEC_OVERRIDE}})
    else $error("permits not loaded from default");
endmodule // tna_ac_chk
bind tna_access_control tna_ac_chk chk_i (
  .CLK_SYS                     (CLK_SYS),
  .SRST                        (SRST),
  .WB_CYC                      (WB_CYC),
  .WB_STB                      (WB_STB),
  .WB_WE                       (WB_WE),
  .WB_ADR                      (WB_ADR),
  .WB_NS                       (WB_NS),
  .WB_DAT_O                    (WB_DAT_O),
  .WB_ACK                      (WB_ACK),
  .SEC_OVERRIDE                (SEC_OVERRIDE),
  .XLATE_EN_S                  (XLATE_EN_S),
  .XLATE_EN_NS                 (XLATE_EN_NS),
  .XLATE_REQ                   (XLATE_REQ),
  .XLATE_GNT                   (XLATE_GNT),
  .NODE_PRIORITY               (NODE_PRIORITY),
  .NONSECURE_INIT_PERMIT       (NONSECURE_INIT_PERMIT),
  .NONSECURE_ERROR_REGS_PERMIT (NONSECURE_ERROR_REGS_PERMIT),
  .NONSECURE_UARCH_PERMIT      (NONSECURE_UARCH_PERMIT),
  .NS_ACCESS_DENIED            (NS_ACCESS_DENIED)
);
`default_nettype wire

// ==== dv/tna_access_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tna_access_control_tb import tna_pkg::*;;
  logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, ns = 0, so = 1, ens = 0, enn = 0, ack, den;
  logic [15:0] adr = 0, pri;
  logic [31:0] dw = 0, dr, rs = 32'h555B, wv, nc[8];
  logic [7:0]  con = 0, ats = 0, req = 0, gnt, exc;
  logic [2:0]  pmo;
  logic [32:0] q[$], me;
  int bad_count = 0, cmp_count = 0;
  always #2.5 clk = ~clk;
  tna_access_control dut (.CLK_SYS(clk), .SRST(srst), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we), .WB_ADR(adr),
    .WB_SEL(4'hF), .WB_DAT_I(dw), .WB_NS(ns), .WB_DAT_O(dr), .WB_ACK(ack), .SEC_OVERRIDE(so), .XLATE_EN_S(ens),
    .XLATE_EN_NS(enn), .NODE_CONNECTED(con), .NODE_ATS(ats), .XLATE_REQ(req), .XLATE_GNT(gnt), .NODE_PRIORITY(pri),
    .NODE_INVAL_EXCLUDE(exc), .NONSECURE_INIT_PERMIT(pmo[2]), .NONSECURE_ERROR_REGS_PERMIT(pmo[1]),
    .NONSECURE_UARCH_PERMIT(pmo[0]), .NS_ACCESS_DENIED(den));
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic [7:0] gexp(logic [7:0] r);
    int b = -1;
    for (int i = 0; i < 8; i++) if (r[i] && (b < 0 || nc[i][1:0] > nc[b][1:0])) b = i;
    return b < 0 ? 8'h00 : 8'h01 << b;
  endfunction
  task automatic chk(input string nm, input logic [32:0] e, s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask
  // Expected {denied, data} is queued before the request goes out
  task automatic bus(input logic w, n, input logic [15:0] a, input logic [31:0] d, input logic [32:0] e);
    q.push_back(e);
    @(posedge clk);
    {cyc, stb, we, ns, adr, dw} <= {2'b11, w, n, a, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    {cyc, stb} <= 2'b00;
  endtask
  always @(posedge clk) if (ack === 1'b1) begin
    me = q.size() > 0 ? q.pop_front() : {1'b1, 32'hFFFF_FFFF};
    chk("bus", {me[32], we ? 32'h0 : me[31:0]}, {den, we ? 32'h0 : dr});
  end
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #50000;
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 0;
    con <= 8'(rnd());
    ats <= 8'(rnd());
    @(posedge clk);
    chk("permits", 33'h7, 33'(pmo));
    bus(0, 1, SCR_OFS, 0, {1'b1, 32'h0});
    bus(1, 1, SCR_OFS, 0, {1'b1, 32'h0});
    bus(0, 0, SCR_OFS, 0, {1'b0, SCR_MASK});
    bus(0, 0, 16'h0100, 0, 33'h0);
    for (int i = 0; i < 8; i++) bus(0, 0, NSTAT_LO + 16'(4*i), 0, {31'h0, con[i] ? {ats[i], 1'b1} : 2'b00});
    for (int i = 0; i < 8; i++) begin
      nc[i] = rnd();
      bus(1, 0, NCTRL_LO + 16'(4*i), nc[i], 33'h0);
      nc[i] &= NC_MASK;
    end
    for (int i = 0; i < 8; i++) begin
      bus(0, 0, NCTRL_LO + 16'(4*i), 0, {1'b0, nc[i]});
      chk("prio", 33'(nc[i][1:0]), 33'(pri[2*i+:2]));
      chk("excl", 33'(nc[i][4] & ~(con[i] & ats[i])), 33'(exc[i]));
    end
    // Invalidate everything before translation comes on
    bus(1, 0, INIT_OFS, 32'h1, 33'h0);
    ens <= 1;
    bus(1, 0, NCTRL_LO, ~nc[0], 33'h0);
    {ens, enn} <= 2'b01;
    bus(1, 0, NCTRL_LO, ~nc[0], 33'h0);
    enn <= 0;
    bus(0, 0, NCTRL_LO, 0, {1'b0, nc[0]});
    for (int v = 0; v < 8; v++) begin
      wv = (rnd() & ~SCR_MASK) | {28'h0, v[2], 1'b0, v[1:0]};
      bus(1, 0, SCR_OFS, wv, 33'h0);
      bus(0, 0, SCR_OFS, 0, {29'h0, v[2], 1'b0, v[1:0]});
      bus(0, 1, INIT_OFS, 0, {~v[2], 32'h0});
      bus(0, 1, ERR_LO, 0, {~v[1], 32'h0});
      bus(0, 1, NCTRL_LO + 4, 0, {~v[0], v[0] ? nc[1] : 32'h0});
      wv = rnd();
      bus(1, 1, NCTRL_LO + 4, wv, {~v[0], 32'h0});
      if (v[0]) nc[1] = wv & NC_MASK;
      bus(0, 1, NSTAT_LO + 4, 0, {~v[0], 30'h0, v[0] & con[1] ? {ats[1], 1'b1} : 2'b00});
    end
    for (int k = 0; k < 24; k++) begin
      @(posedge clk);
      req <= 8'(rnd());
      @(posedge clk);
      @(negedge clk);
      chk("grant", 33'(gexp(req)), 33'(gnt));
    end
    @(posedge clk);
    {so, srst} <= 2'b01;
    repeat (3) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    chk("permits", 33'h0, 33'(pmo));
    bus(0, 1, NSTAT_LO, 0, {1'b1, 32'h0});
    bus(0, 0, NCTRL_LO, 0, 33'h0);
    repeat (3) @(posedge clk);
    chk("pending", 33'h0, 33'(q.size()));
    stop_test();
  end
endmodule // tna_access_control_tb
`default_nettype wire
